//--- dv/ddct_ctrl_sva.sv
// Command spacing checks on the memory pins of ddct_ctrl.
// Assumes fast grade figures apply while grade_sel is zero.
`include "ddct_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddct_ctrl_sva
(
   // Clock, reset, grade
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic [1:0]  grade_sel,
   // Pins and answers
   input wire logic        ddr_cs_n,
   input wire logic        ddr_ras_n,
   input wire logic        ddr_cas_n,
   input wire logic        ddr_we_n,
   input wire logic [1:0]  ddr_ba,
   input wire logic [11:0] ddr_addr,
   input wire logic        ddr_dq_oe_n,
   input wire logic        rd_valid
);
   wire [3:0] cmd = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
   wire       f   = grade_sel == 2'h0;
   wire       act = cmd == `DDCT_CMD_ACT;
   wire       rd  = cmd == `DDCT_CMD_RD;
   wire       wr  = cmd == `DDCT_CMD_WR;
   wire       pre = cmd == `DDCT_CMD_PRE;
   wire       rf  = cmd == `DDCT_CMD_REF;
   wire       mrs = cmd == `DDCT_CMD_MRS;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);
   a_act_read_gap:
      assert property (f && act |-> ##1 (!rd) [*4])
      else $error("read too soon after activate");
   a_act_write_gap:
      assert property (f && act |-> ##1 (!wr) [*2])
      else $error("write too soon after activate");
   a_act_pre_gap:
      assert property (f && act |-> ##1 (!pre) [*8] ##1 !pre)
      else $error("row closed too early");
   a_pre_act_gap:
      assert property (f && pre |-> ##1 (!(act && $stable(ddr_ba))) [*4])
      else $error("activate too soon after precharge");
   a_bank_act_gap:
      assert property (f && act |-> ##1 (!act) [*2])
      else $error("activates too close");
   a_ref_gap:
      assert property (f && rf |-> ##1 (!(act || rf)) [*8] ##1 (!(act || rf)) [*8])
      else $error("command too soon after refresh");
   a_wr_pre_gap:
      assert property (f && wr |-> ##1 (!pre) [*3])
      else $error("precharge too soon after write");
   a_wr_read_gap:
      assert property (wr |-> ##1 (!rd) [*2])
      else $error("read too soon after write");
   a_mode_gap:
      assert property (mrs |=> cmd == `DDCT_CMD_NOP)
      else $error("command right after mode write");
   a_ext_mode_bits:
      assert property (mrs && ddr_ba == 2'h1 |-> (ddr_addr & 12'hfbc) == 12'h000)
      else $error("reserved bit set in extended mode write");
   a_mode_latency:
      assert property (mrs && ddr_ba == 2'h0 |-> ddr_addr[6:4] == 3'h3)
      else $error("read latency not three");
   a_write_pair:
      assert property (wr |-> !ddr_dq_oe_n ##1 ddr_dq_oe_n)
      else $error("write data not one burst after write");
   a_read_answer:
      assert property (rd |-> ##6 rd_valid)
      else $error("read answer late");
endmodule // ddct_ctrl_sva
bind ddct_ctrl ddct_ctrl_sva u_sva (.*);
`default_nettype wire

//--- dv/ddct_ctrl_tb_top.sv
// Self-checking bench for ddct_ctrl against the memory model.
// Assumes fast grade and a shortened row-open limit of 200 cycles.
`timescale 1ns/1ps
`default_nettype none
module ddct_ctrl_tb_top;
   logic        mclk, reset, sr_req, pd_req, req_valid, req_write, req_autopre;
   logic [1:0]  grade_sel, drv_strength, req_bank;
   logic [11:0] req_row;
   logic [7:0]  req_col, req_wmask;
   logic [63:0] req_wdata;
   wire         init_done, req_ready, rd_valid, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n;
   wire         ddr_we_n, ddr_dq_oe_n, ddr_dqs_o, ddr_dqs_oe_n;
   wire  [1:0]  ddr_ba;
   wire  [11:0] ddr_addr;
   wire  [7:0]  ddr_dm;
   wire  [63:0] rd_data, ddr_dq_o;
   logic [63:0] ddr_dq_i;
   int          failures;
   int          compares;
   localparam logic [63:0] PA = 64'h0123456789abcdef;
   localparam logic [63:0] PB = 64'hfedcba9876543210;
   ddct_ctrl #(.RAS_MAX_CYC(200)) uut (.*);
   ddct_mem_model u_mem (.mclk(mclk), .cmd({ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n}),
      .ba(ddr_ba), .addr(ddr_addr), .dq_o(ddr_dq_o), .dq_oe_n(ddr_dq_oe_n), .dm(ddr_dm),
      .dq_i(ddr_dq_i));
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic complete_run;
      if (failures == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until the edge where ready is seen high
   task automatic xfer(input logic w, input logic [1:0] b, input logic [11:0] r,
                       input logic [7:0] c, input logic [63:0] d, input logic [7:0] m);
      @(posedge mclk);
      req_valid <= 1'b1;
      req_write <= w;
      req_bank <= b;
      req_row <= r;
      req_col <= c;
      req_wdata <= d;
      req_wmask <= m;
      do
         @(negedge mclk);
      while (req_ready !== 1'b1);
      @(posedge mclk);
      req_valid <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
                     input logic [63:0] e);
      int n;
      n = 0;
      xfer(1'b0, b, r, c, 64'h0, 8'h00);
      while (rd_valid !== 1'b1 && n < 500)
      begin
         @(negedge mclk);
         n++;
      end
      chk("rd_valid", 64'h1, {63'h0, rd_valid});
      chk("rd_data", e, rd_data);
   endtask
   task automatic t_write_read;
      xfer(1'b1, 2'h0, 12'h005, 8'h04, PA, 8'h00);
      rd(2'h0, 12'h005, 8'h04, PA);
   endtask
   task automatic t_mask;
      xfer(1'b1, 2'h0, 12'h005, 8'h04, PB, 8'h0f);
      rd(2'h0, 12'h005, 8'h04, {PB[63:32], PA[31:0]});
   endtask
   // Row misses force precharge and a fresh activate
   task automatic t_row_miss;
      req_autopre <= 1'b1;
      xfer(1'b1, 2'h0, 12'h009, 8'h04, PB, 8'h00);
      req_autopre <= 1'b0;
      rd(2'h3, 12'h001, 8'h02, 64'h0);
      rd(2'h0, 12'h005, 8'h04, {PB[63:32], PA[31:0]});
   endtask
   // Self refresh then power-down; data must survive both
   task automatic t_low_power;
      time t0;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge mclk);
         sr_req <= (i == 0);
         pd_req <= (i == 1);
         repeat (300) @(posedge mclk);
         @(negedge mclk);
         // A due refresh briefly wakes power-down; check once asleep again
         while (i == 1 && ddr_cke === 1'b1)
            @(negedge mclk);
         chk("req_ready", 64'h0, {63'h0, req_ready});
         chk("ddr_cke", 64'h0, {63'h0, ddr_cke});
         @(posedge mclk);
         sr_req <= 1'b0;
         pd_req <= 1'b0;
         t0 = $time;
         rd(2'h0, 12'h009, 8'h04, PB);
         if (i == 0)
            chk("exit_wait", 64'h1, {63'h0, ($time - t0) >= 200 * 50});
      end
   endtask
   initial
   begin
      #(30000 * 50);
      failures++;
      complete_run;
   end
   initial
   begin
      reset <= 1'b1;
      grade_sel <= 2'h0;
      drv_strength <= 2'h3;
      sr_req <= 1'b0;
      pd_req <= 1'b0;
      req_valid <= 1'b0;
      req_write <= 1'b0;
      req_autopre <= 1'b0;
      req_bank <= 2'h0;
      req_row <= 12'h000;
      req_col <= 8'h00;
      req_wdata <= 64'h0;
      req_wmask <= 8'h00;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      for (int n = 0; n < 6000 && init_done !== 1'b1; n++)
         @(negedge mclk);
      chk("init_done", 64'h1, {63'h0, init_done});
      t_write_read;
      t_mask;
      t_row_miss;
      t_low_power;
      complete_run;
   end
endmodule // ddct_ctrl_tb_top
`default_nettype wire

//--- dv/ddct_mem_model.sv
// Behavioural memory device: stores write bursts, answers reads.
// Assumes one BL2 burst per mclk cycle and read data in cycle c+3.
`include "ddct_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddct_mem_model
(
   // Clock and command pins
   input  wire logic [3:0]  cmd,
   input  wire logic        mclk,
   input  wire logic [1:0]  ba,
   input  wire logic [11:0] addr,
   // Data pins
   input  wire logic [63:0] dq_o,
   input  wire logic        dq_oe_n,
   input  wire logic [7:0]  dm,
   output var  logic [63:0] dq_i
);
   logic [63:0] mem [int];
   logic [11:0] row_q [4];
   int          wkey_q;
   int          rkey1_q;
   int          rkey2_q;
   logic [1:0]  rv_q;
   initial dq_i = 64'h0;
   always @(posedge mclk)
   begin
      if (cmd == `DDCT_CMD_ACT)
         row_q[ba] <= addr;
      wkey_q = {ba, row_q[ba], addr[7:0]};
      // Both beats land together, in the cycle of the write command
      if (dq_oe_n == 1'b0)
      begin
         if (!mem.exists(wkey_q))
            mem[wkey_q] = 64'h0;
         for (int i = 0; i < 8; i++)
            if (!dm[i])
               mem[wkey_q][8*i +: 8] = dq_o[8*i +: 8];
      end
      rv_q <= {rv_q[0], cmd == `DDCT_CMD_RD};
      rkey1_q <= {ba, row_q[ba], addr[7:0]};
      rkey2_q <= rkey1_q;
      // Outside the answer cycle the lines toggle so stale data never matches
      if (rv_q[1] === 1'b1)
         dq_i <= mem.exists(rkey2_q) ? mem[rkey2_q] : 64'h0;
      else
         dq_i <= ~dq_i;
   end
endmodule // ddct_mem_model
`default_nettype wire

//--- hdl/ddct_ctrl.v
// Command controller for a four-bank DDR memory: init, refresh, gap checks.
// Assumes mclk is forwarded as the memory clock; request port is on mclk.
`include "ddct_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddct_ctrl
#(
   parameter RAS_MAX_CYC = `DDCT_RAS_MAX_CYC
)
(
   // Clock and reset
   input  wire        mclk,
   input  wire        reset,
   // Configuration
   input  wire [1:0]  grade_sel,
   input  wire [1:0]  drv_strength,
   input  wire        sr_req,
   input  wire        pd_req,
   output wire        init_done,
   // Request port
   input  wire        req_valid,
   output wire        req_ready,
   input  wire        req_write,
   input  wire        req_autopre,
   input  wire [1:0]  req_bank,
   input  wire [11:0] req_row,
   input  wire [7:0]  req_col,
   input  wire [63:0] req_wdata,
   input  wire [7:0]  req_wmask,
   output wire        rd_valid,
   output wire [63:0] rd_data,
   // Memory pins
   output wire        ddr_cke,
   output wire        ddr_cs_n,
   output wire        ddr_ras_n,
   output wire        ddr_cas_n,
   output wire        ddr_we_n,
   output wire [1:0]  ddr_ba,
   output wire [11:0] ddr_addr,
   output wire [63:0] ddr_dq_o,
   input  wire [63:0] ddr_dq_i,
   output wire        ddr_dq_oe_n,
   output wire        ddr_dqs_o,
   output wire        ddr_dqs_oe_n,
   output wire [7:0]  ddr_dm
);

   // ----------------------------------------------------------------
   // States and timers
   // ----------------------------------------------------------------
   localparam [3:0] S_PWR   = 4'h0;
   localparam [3:0] S_IPRE  = 4'h1;
   localparam [3:0] S_IEMRS = 4'h2;
   localparam [3:0] S_IMRS  = 4'h3;
   localparam [3:0] S_IDLL  = 4'h4;
   localparam [3:0] S_IPRE2 = 4'h5;
   localparam [3:0] S_IREF  = 4'h6;
   localparam [3:0] S_IMRS2 = 4'h7;
   localparam [3:0] S_RUN   = 4'h8;
   localparam [3:0] S_SREF  = 4'h9;
   localparam [3:0] S_PDN   = 4'ha;

   localparam T_RRD = 0, T_RFC = 1, T_MRD = 2, T_RCDR = 3, T_RCDW = 4, T_RAS = 5;
   localparam T_WR = 6, T_CDLR = 7, T_XSR = 8, T_CCD = 9, T_PDX = 10, T_ACT0 = 11;
   localparam NT = 15;

   function [7:0] gap;
      input [1:0] g;
      input [7:0] f;
      input [7:0] s;
      input [7:0] r;
      begin
         case (g)
            `DDCT_GRADE_FAST: gap = f;
            `DDCT_GRADE_RED:  gap = r;
            default:          gap = s;
         endcase
      end
   endfunction

   function [7:0] dec;
      input [7:0] x;
      begin
         dec = (x == 8'h00) ? 8'h00 : x - 8'h01;
      end
   endfunction

   // Keep the longer of the running wait and a new gap
   function [7:0] gl;
      input [7:0] cur;
      input [7:0] g;
      begin
         gl = (dec(cur) > g - 8'h01) ? dec(cur) : g - 8'h01;
      end
   endfunction

   reg  [7:0]  tq [0:NT-1];
   reg  [3:0]  state_q, state_d;
   reg  [3:0]  cmd_q, cmd_d;
   reg  [1:0]  ba_q, ba_d;
   reg  [11:0] addr_q, addr_d;
   reg         cke_q, cke_d;
   reg  [11:0] cnt_q;
   reg  [1:0]  irefs_q;
   reg         done_q, ready_q;
   reg         busy_q, rq_write_q, rq_ap_q;
   reg  [1:0]  rq_bank_q;
   reg  [11:0] rq_row_q;
   reg  [7:0]  rq_col_q;
   reg  [63:0] rq_wdata_q;
   reg  [7:0]  rq_wmask_q;
   reg         open_q;
   reg  [1:0]  open_bank_q;
   reg  [11:0] open_row_q;
   reg  [16:0] ras_cnt_q;
   reg  [63:0] dq_q;
   reg  [7:0]  dm_q;
   reg         dq_oe_n_q, dqs_q;
   reg  [`DDCT_RD_PIPE-1:0] rd_pipe_q;
   reg         rd_valid_q;
   reg  [63:0] rd_data_q;
   reg         iss_act, iss_rd, iss_wr, iss_pre, iss_ref, iss_mrs;
   reg         pre_all, sr_exit, pd_exit, busy_d;
   integer     i;

   wire        ref_due;
   wire [63:0] dq_sync;
   wire        take = req_valid && ready_q;
   wire        hit  = open_q && open_bank_q == rq_bank_q && open_row_q == rq_row_q;
   wire        banks_idle = tq[T_ACT0] == 8'h00 && tq[T_ACT0+1] == 8'h00 &&
                            tq[T_ACT0+2] == 8'h00 && tq[T_ACT0+3] == 8'h00;
   wire        quiet = banks_idle && tq[T_RFC] == 8'h00 && tq[T_MRD] == 8'h00;
   wire        cmd_ok = tq[T_MRD] == 8'h00 && tq[T_PDX] == 8'h00 &&
                        tq[T_XSR] == 8'h00;
   wire        ras_long = {15'h0, ras_cnt_q} >= RAS_MAX_CYC - `DDCT_RAS_GUARD;
   wire        pre_ok = tq[T_RAS] == 8'h00 && tq[T_WR] == 8'h00 &&
                        tq[T_CCD] == 8'h00;
   wire        need_close = open_q && (ref_due || sr_req || ras_long || (busy_q && !hit));
   wire [7:0]  g_rc   = gap(grade_sel, `DDCT_RC_F, `DDCT_RC_S, `DDCT_RC_R);
   wire [7:0]  g_rfc  = gap(grade_sel, `DDCT_RFC_F, `DDCT_RFC_S, `DDCT_RFC_R);
   wire [7:0]  g_ras  = gap(grade_sel, `DDCT_RAS_F, `DDCT_RAS_S, `DDCT_RAS_R);
   wire [7:0]  g_rcdr = gap(grade_sel, `DDCT_RCDR_F, `DDCT_RCDR_S, `DDCT_RCDR_R);
   wire [7:0]  g_rcdw = gap(grade_sel, `DDCT_RCDW_F, `DDCT_RCDW_S, `DDCT_RCDW_R);
   wire [7:0]  g_rp   = gap(grade_sel, `DDCT_RP_F, `DDCT_RP_S, `DDCT_RP_R);
   wire [7:0]  g_rrd  = gap(grade_sel, `DDCT_RRD_F, `DDCT_RRD_S, `DDCT_RRD_R);
   wire [7:0]  g_wr   = gap(grade_sel, `DDCT_WR_F, `DDCT_WR_S, `DDCT_WR_R);
   wire [7:0]  g_dal  = gap(grade_sel, `DDCT_DAL_F, `DDCT_DAL_S, `DDCT_DAL_R);

   ddct_ref_tick u_ref
   (
      .mclk     (mclk),
      .reset    (reset),
      .enable   (done_q),
      .ref_done (iss_ref && state_q == S_RUN),
      .ref_due  (ref_due)
   );

   ddct_sync #(.W(64)) u_dq_sync
   (
      .mclk  (mclk),
      .reset (reset),
      .d_in  (ddr_dq_i),
      .d_out (dq_sync)
   );

   // ----------------------------------------------------------------
   // Command selection
   // ----------------------------------------------------------------
   always @*
   begin
      state_d = state_q;
      cmd_d   = `DDCT_CMD_NOP;
      ba_d    = ba_q;
      addr_d  = addr_q;
      cke_d   = cke_q;
      iss_act = 1'b0;
      iss_rd  = 1'b0;
      iss_wr  = 1'b0;
      iss_pre = 1'b0;
      iss_ref = 1'b0;
      iss_mrs = 1'b0;
      pre_all = 1'b0;
      sr_exit = 1'b0;
      pd_exit = 1'b0;
      case (state_q)
         S_PWR:
            if (cnt_q == 12'h000)
            begin
               cke_d   = 1'b1;
               state_d = S_IPRE;
            end
         S_IPRE, S_IPRE2:
            if (quiet)
            begin
               cmd_d   = `DDCT_CMD_PRE;
               addr_d  = `DDCT_AP_MASK;
               iss_pre = 1'b1;
               pre_all = 1'b1;
               state_d = (state_q == S_IPRE) ? S_IEMRS : S_IREF;
            end
         S_IEMRS:
            if (quiet)
            begin
               cmd_d   = `DDCT_CMD_MRS;
               ba_d    = `DDCT_BA_EXTENDED_MODE_WRITE;
               // Only drive strength bits set; DLL enabled, rest zero
               addr_d  = {5'h00, drv_strength[1], 4'h0, drv_strength[0], 1'b0};
               iss_mrs = 1'b1;
               state_d = S_IMRS;
            end
         S_IMRS, S_IMRS2:
            if (quiet)
            begin
               cmd_d   = `DDCT_CMD_MRS;
               ba_d    = `DDCT_BA_MRS;
               addr_d  = {3'h0, state_q == S_IMRS, 1'b0, `DDCT_MRS_CL3, 1'b0,
                          `DDCT_MRS_BL2};
               iss_mrs = 1'b1;
               state_d = (state_q == S_IMRS) ? S_IDLL : S_RUN;
            end
         S_IDLL:
            if (cnt_q == 12'h000)
               state_d = S_IPRE2;
         S_IREF:
            if (irefs_q == `DDCT_INIT_REFS)
               state_d = S_IMRS2;
            else if (quiet)
            begin
               cmd_d   = `DDCT_CMD_REF;
               iss_ref = 1'b1;
            end
         S_RUN:
            if (!cmd_ok)
               state_d = S_RUN;
            else if (need_close)
            begin
               if (pre_ok)
               begin
                  cmd_d   = `DDCT_CMD_PRE;
                  ba_d    = open_bank_q;
                  addr_d  = 12'h000;
                  iss_pre = 1'b1;
               end
            end
            else if (ref_due || sr_req)
            begin
               if (quiet)
               begin
                  cmd_d   = `DDCT_CMD_REF;
                  iss_ref = 1'b1;
                  if (!ref_due)
                  begin
                     cke_d   = 1'b0;
                     state_d = S_SREF;
                  end
               end
            end
            else if (busy_q && hit)
            begin
               // Column commands may run back to back
               if (tq[T_CCD] == 8'h00 && (rq_write_q ? tq[T_RCDW] == 8'h00 :
                   (tq[T_RCDR] == 8'h00 && tq[T_CDLR] == 8'h00)))
               begin
                  cmd_d  = rq_write_q ? `DDCT_CMD_WR : `DDCT_CMD_RD;
                  ba_d   = rq_bank_q;
                  addr_d = {3'h0, rq_ap_q && rq_write_q, rq_col_q};
                  iss_wr = rq_write_q;
                  iss_rd = !rq_write_q;
               end
            end
            else if (busy_q)
            begin
               if (tq[T_ACT0 + rq_bank_q] == 8'h00 && tq[T_RRD] == 8'h00 &&
                   tq[T_RFC] == 8'h00)
               begin
                  cmd_d   = `DDCT_CMD_ACT;
                  ba_d    = rq_bank_q;
                  addr_d  = rq_row_q;
                  iss_act = 1'b1;
               end
            end
            else if (pd_req)
            begin
               cke_d   = 1'b0;
               state_d = S_PDN;
            end
         S_SREF:
            if (!sr_req)
            begin
               cke_d   = 1'b1;
               sr_exit = 1'b1;
               state_d = S_RUN;
            end
         S_PDN:
            if (!pd_req || ref_due || busy_q)
            begin
               cke_d   = 1'b1;
               pd_exit = 1'b1;
               state_d = S_RUN;
            end
         default:
            state_d = S_PWR;
      endcase
      busy_d = (busy_q && !(iss_rd || iss_wr)) || take;
   end

   // ----------------------------------------------------------------
   // Gap timers
   // ----------------------------------------------------------------
   always @(posedge mclk)
   begin
      for (i = 0; i < NT; i = i + 1)
         tq[i] <= reset ? 8'h00 : dec(tq[i]);
      if (!reset)
      begin
         if (iss_act)
         begin
            tq[T_RRD]             <= gl(tq[T_RRD], g_rrd);
            tq[T_RCDR]            <= gl(tq[T_RCDR], g_rcdr);
            tq[T_RCDW]            <= gl(tq[T_RCDW], g_rcdw);
            tq[T_RAS]             <= gl(tq[T_RAS], g_ras);
            tq[T_ACT0 + rq_bank_q] <= gl(tq[T_ACT0 + rq_bank_q], g_rc);
         end
         if (iss_pre)
            for (i = 0; i < 4; i = i + 1)
               if (pre_all || open_bank_q == i[1:0])
                  tq[T_ACT0 + i] <= gl(tq[T_ACT0 + i], g_rp);
         if (iss_wr)
         begin
            tq[T_WR]   <= gl(tq[T_WR], g_wr + `DDCT_WDATA_LAG);
            tq[T_CDLR] <= gl(tq[T_CDLR], `DDCT_CDLR_CYC + `DDCT_WDATA_LAG);
            if (rq_ap_q)
               tq[T_ACT0 + rq_bank_q] <= gl(tq[T_ACT0 + rq_bank_q],
                                            g_dal + `DDCT_WDATA_LAG);
         end
         if (iss_wr || iss_rd)
            tq[T_CCD] <= gl(tq[T_CCD], `DDCT_CCD_CYC);
         if (iss_ref)
            tq[T_RFC] <= gl(tq[T_RFC], g_rfc);
         if (iss_mrs)
            tq[T_MRD] <= gl(tq[T_MRD], `DDCT_MRD_CYC);
         if (sr_exit)
            tq[T_XSR] <= gl(tq[T_XSR], `DDCT_XSR_CYC);
         if (pd_exit)
            tq[T_PDX] <= gl(tq[T_PDX], `DDCT_PDX_CYC);
      end
   end

   // ----------------------------------------------------------------
   // Sequencing, request and data registers
   // ----------------------------------------------------------------
   always @(posedge mclk)
   begin
      if (reset)
      begin
         state_q     <= S_PWR;
         cmd_q       <= `DDCT_CMD_NOP;
         ba_q        <= 2'h0;
         addr_q      <= 12'h000;
         cke_q       <= 1'b0;
         cnt_q       <= `DDCT_INIT_WAIT_CYC - 12'h001;
         irefs_q     <= 2'h0;
         done_q      <= 1'b0;
         ready_q     <= 1'b0;
         busy_q      <= 1'b0;
         open_q      <= 1'b0;
         open_bank_q <= 2'h0;
         open_row_q  <= 12'h000;
         ras_cnt_q   <= 17'h00000;
         dq_oe_n_q   <= 1'b1;
         dqs_q       <= 1'b0;
         rd_pipe_q   <= {`DDCT_RD_PIPE{1'b0}};
         rd_valid_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cmd_q   <= cmd_d;
         ba_q    <= ba_d;
         addr_q  <= addr_d;
         cke_q   <= cke_d;
         if (iss_mrs && state_q == S_IMRS)
            cnt_q <= `DDCT_DLL_LOCK_CYC - 12'h001;
         else if (cnt_q != 12'h000)
            cnt_q <= cnt_q - 12'h001;
         if (iss_ref && state_q == S_IREF)
            irefs_q <= irefs_q + 2'h1;
         done_q  <= done_q || state_d == S_RUN;
         busy_q  <= busy_d;
         ready_q <= state_d == S_RUN && !busy_d && !sr_req && !pd_req;
         if (iss_act)
         begin
            open_q      <= 1'b1;
            open_bank_q <= rq_bank_q;
            open_row_q  <= rq_row_q;
         end
         else if (iss_pre || (iss_wr && rq_ap_q))
            open_q <= 1'b0;
         // Rows are forced shut well before the longest open time
         ras_cnt_q <= (iss_act || !open_q) ? 17'h00000 : ras_cnt_q + 17'h00001;
         // Both beats of a burst go out together, so the count stays even
         dq_oe_n_q  <= !iss_wr;
         dqs_q      <= iss_wr;
         rd_pipe_q  <= {rd_pipe_q[`DDCT_RD_PIPE-2:0], iss_rd};
         rd_valid_q <= rd_pipe_q[`DDCT_RD_PIPE-1];
      end
   end

   always @(posedge mclk)
   begin
      if (take)
      begin
         rq_write_q <= req_write;
         rq_ap_q    <= req_autopre;
         rq_bank_q  <= req_bank;
         rq_row_q   <= req_row;
         rq_col_q   <= req_col;
         rq_wdata_q <= req_wdata;
         rq_wmask_q <= req_wmask;
      end
      if (iss_wr)
      begin
         dq_q <= rq_wdata_q;
         dm_q <= rq_wmask_q;
      end
      if (rd_pipe_q[`DDCT_RD_PIPE-1])
         rd_data_q <= dq_sync;
   end

   assign init_done    = done_q;
   assign req_ready    = ready_q;
   assign rd_valid     = rd_valid_q;
   assign rd_data      = rd_data_q;
   assign ddr_cke      = cke_q;
   assign ddr_cs_n     = cmd_q[3];
   assign ddr_ras_n    = cmd_q[2];
   assign ddr_cas_n    = cmd_q[1];
   assign ddr_we_n     = cmd_q[0];
   assign ddr_ba       = ba_q;
   assign ddr_addr     = addr_q;
   assign ddr_dq_o     = dq_q;
   assign ddr_dq_oe_n  = dq_oe_n_q;
   assign ddr_dqs_o    = dqs_q;
   assign ddr_dqs_oe_n = dq_oe_n_q;
   assign ddr_dm       = dm_q;

endmodule // ddct_ctrl
`default_nettype wire

//--- hdl/ddct_defs.vh
// Constants of the DDR command controller: command codes, mode words, gaps.
// Assumes the memory command clock is mclk itself, 50 ns per cycle.
// Functional notes
// - Same-bank activates spaced by row cycle.
// - Refresh blocks activate/refresh for refresh cycle.
// - Row open at least minimum, below maximum.
// - Activate to read waits read delay.
// - Activate to write waits write delay.
// - Precharge to activate waits precharge time.
// - Activates to different banks keep bank gap.
// - Last write beat to precharge waits recovery.
// - Last write beat to read waits two.
// - Column commands may follow one apart.
// - Mode writes block everything for two cycles.
// - Auto-precharge write blocks activate for recovery.
// - Self refresh exit waits 200 before reading.
// - Power-down exit waits one clock plus setup.
// - Refreshes average no longer than 7.8 us.
// - Writes always carry an even beat count.
// - Extended mode reserved bits driven zero.
// - Reduced grade uses the 166 MHz gap set.
// - Read latency programmed as three.
// - Extended mode write drives only allowed bits.
`ifndef DDCT_DEFS_VH
`define DDCT_DEFS_VH

// Clock and long waits
`define DDCT_CLK_PERIOD_NS  50
`define DDCT_INIT_WAIT_US   200
// Cycle counts are the waits above in 50 ns cycles, rounded up
`define DDCT_INIT_WAIT_CYC  12'hfa0
`define DDCT_REF_INT_NS     7800
`define DDCT_REF_CYC        8'h9c
`define DDCT_TIS_NS         1
`define DDCT_PDX_CYC        8'h02
`define DDCT_RAS_MAX_CYC    100000
`define DDCT_RAS_GUARD      64

// Fixed gaps in cycles
`define DDCT_DLL_LOCK_CYC   12'hc8
`define DDCT_XSR_CYC        8'hc8
`define DDCT_MRD_CYC        8'h02
`define DDCT_CDLR_CYC       8'h02
`define DDCT_CCD_CYC        8'h01
`define DDCT_WDATA_LAG      8'h01
`define DDCT_INIT_REFS      2'h2
`define DDCT_READ_LATENCY   3
`define DDCT_SYNC_STAGES    2
`define DDCT_RD_PIPE        (`DDCT_READ_LATENCY+`DDCT_SYNC_STAGES+1)

// Speed grades
`define DDCT_GRADE_FAST     2'h0
`define DDCT_GRADE_SLOW     2'h1
`define DDCT_GRADE_RED      2'h2

// Grade gaps: fast, slow, reduced
`define DDCT_RC_F   8'h0f
`define DDCT_RC_S   8'h0c
`define DDCT_RC_R   8'h0a
`define DDCT_RFC_F  8'h11
`define DDCT_RFC_S  8'h0e
`define DDCT_RFC_R  8'h0c
`define DDCT_RAS_F  8'h0a
`define DDCT_RAS_S  8'h08
`define DDCT_RAS_R  8'h07
`define DDCT_RCDR_F 8'h05
`define DDCT_RCDR_S 8'h04
`define DDCT_RCDR_R 8'h03
`define DDCT_RCDW_F 8'h03
`define DDCT_RCDW_S 8'h02
`define DDCT_RCDW_R 8'h02
`define DDCT_RP_F   8'h05
`define DDCT_RP_S   8'h04
`define DDCT_RP_R   8'h03
`define DDCT_RRD_F  8'h03
`define DDCT_RRD_S  8'h02
`define DDCT_RRD_R  8'h02
`define DDCT_WR_F   8'h03
`define DDCT_WR_S   8'h02
`define DDCT_WR_R   8'h02
`define DDCT_DAL_F  8'h08
`define DDCT_DAL_S  8'h06
`define DDCT_DAL_R  8'h05

// Commands as {cs_n, ras_n, cas_n, we_n}
`define DDCT_CMD_NOP 4'h7
`define DDCT_CMD_ACT 4'h3
`define DDCT_CMD_RD  4'h5
`define DDCT_CMD_WR  4'h4
`define DDCT_CMD_PRE 4'h2
`define DDCT_CMD_REF 4'h1
`define DDCT_CMD_MRS 4'h0

// Mode words
`define DDCT_AP_MASK     12'h100
`define DDCT_BA_MRS      2'h0
`define DDCT_BA_EXTENDED_MODE_WRITE     2'h1
`define DDCT_MRS_BL2     3'h1
`define DDCT_MRS_CL3     3'h3

`endif

//--- hdl/ddct_ref_tick.v
// Refresh interval divider and owed-refresh counter.
// Assumes ref_done pulses once per refresh command issued.
`include "ddct_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddct_ref_tick
(
   // Clock and reset
   input  wire       mclk,
   input  wire       reset,
   // Control
   input  wire       enable,
   input  wire       ref_done,
   output wire       ref_due
);

   reg [7:0] div_q;
   reg [2:0] owed_q;
   wire      tick;

   assign tick    = enable && (div_q == 8'h00);
   assign ref_due = (owed_q != 3'h0);

   // Owed count keeps the average rate even when a refresh is late
   always @(posedge mclk)
   begin
      if (reset || !enable)
      begin
         div_q  <= 8'h00;
         owed_q <= 3'h0;
      end
      else
      begin
         div_q <= tick ? `DDCT_REF_CYC - 8'h01 : div_q - 8'h01;
         // Tick and a same-cycle refresh cancel: net count unchanged
         if (tick && !ref_done && owed_q != 3'h7)
            owed_q <= owed_q + 3'h1;
         else if (!tick && ref_done && owed_q != 3'h0)
            owed_q <= owed_q - 3'h1;
      end
   end

endmodule // ddct_ref_tick
`default_nettype wire

//--- hdl/ddct_sync.v
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the bus is quasi-static around the sampled cycle.
`timescale 1ns/1ps
`default_nettype none
module ddct_sync
#(
   parameter W = 64
)
(
   // Clock and reset
   input  wire         mclk,
   input  wire         reset,
   // Data
   input  wire [W-1:0] d_in,
   output wire [W-1:0] d_out
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;

   always @(posedge mclk)
   begin
      if (reset)
      begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
      end
      else
      begin
         s1_q <= d_in;
         s2_q <= s1_q;
      end
   end

   assign d_out = s2_q;

endmodule // ddct_sync
`default_nettype wire
